// ---- design/csr_pkg.sv ----
/*
  constants for the clock synthesizer control register bank:
  register offsets, field positions, power-up values, serial port codes.
  assumes nothing beyond a systemverilog compiler.
*/
package csr_pkg;
  // ==========================================================
  // register offsets (low two bits of the command code)
  localparam logic [1:0] OFF_IDENTITY = 2'h0;  // identity byte
  localparam logic [1:0] OFF_OUT_EN   = 2'h1;  // output enable control
  localparam logic [1:0] OFF_SPREAD   = 2'h2;  // spread depth control

  // ==========================================================
  // field positions, output enable control
  localparam int BIT_REF_EN      = 7;  // reference output enable
  localparam int BIT_PROC_SS_EN  = 6;  // processor clock and pll enable
  localparam int BIT_USB_EN      = 5;  // usb rate output enable
  localparam int BIT_SEL_AUD_EN  = 4;  // selectable audio output enable
  localparam int BIT_FIX_AUD_EN  = 3;  // fixed audio output enable
  localparam int BIT_AUD_SEL     = 0;  // audio rate select

  // ==========================================================
  // power-up values
  localparam logic [7:0] RST_OUT_EN  = 8'hf7;  // all on but fixed audio
  localparam logic [7:0] RST_SPREAD  = 8'h02;  // -1.0 % spread
  localparam logic [3:0] REVISION_ID = 4'h2;   // arbitrary value
  localparam logic [3:0] MAKER_ID    = 4'h5;   // arbitrary value

  // ==========================================================
  // serial port codes
  localparam logic [6:0] TARGET_ADDR = 7'h69;  // write form byte 8'hd2
  localparam logic [5:0] BYTE_MODE   = 6'h20;  // upper command bits 100000

  // spread depth codes
  localparam logic [2:0] SS_HALF  = 3'h1;  // -0.5 %
  localparam logic [2:0] SS_ONE   = 3'h2;  // -1.0 %
  localparam logic [2:0] SS_TWO   = 3'h4;  // -2.0 %
  localparam logic [2:0] SS_THREE = 3'h6;  // -3.0 %

  // ==========================================================
  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,  // waiting for a start
    ST_ADDR = 3'b001,  // shifting address byte
    ST_CMD  = 3'b010,  // shifting command byte
    ST_DATA = 3'b011,  // shifting write data byte
    ST_SEND = 3'b100,  // sending read data byte
    ST_ACK  = 3'b101,  // driving acknowledge
    ST_MACK = 3'b110,  // waiting for master acknowledge clock, sda not read
    ST_WAIT = 3'b111   // ignoring until stop or start
  } csr_state_e;
endpackage

// ---- design/csr_spread_decode.sv ----
/*
  spread depth decoder: turns the 3-bit depth code into a one-hot
  depth selection for the spread modulator.
  assumes the code comes straight from the control register.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_spread_decode (
  input  wire logic [2:0] code_i,    // spread depth code
  output logic      [3:0] depth_o,   // one-hot: 0.5,1,2,3 percent
  output logic            spread_o   // any spread active
);
  // ==========================================================
  // depth decode, all other codes give no spread
  always_comb begin
    depth_o = 4'h0;
    case (code_i)
      csr_pkg::SS_HALF:  depth_o = 4'h1;
      csr_pkg::SS_ONE:   depth_o = 4'h2;
      csr_pkg::SS_TWO:   depth_o = 4'h4;
      csr_pkg::SS_THREE: depth_o = 4'h8;
      default:           depth_o = 4'h0;
    endcase
    spread_o = |depth_o;
  end
endmodule
`default_nettype wire

// ---- design/csr_regs.sv ----
/*
  control register bank of a multi-output clock synthesizer with a
  two-wire serial port (byte write and byte read only).
  assumes scl/sda levels arrive synchronous and glitch-free to sys_clk_i,
  and that sys_clk_i is many times faster than the serial clock.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_regs (
  input  wire logic       sys_clk_i,        // system clock, 125 mhz
  input  wire logic       reset_i,          // sync reset, active high
  input  wire logic       scl_i,            // serial clock level
  input  wire logic       sda_i,            // serial data level
  output logic            sda_o,            // serial data out, always 0
  output logic            sda_oe_o,         // pull sda low while high
  output logic            ref_en_o,         // reference output enable
  output logic            proc_clk_en_o,    // processor clock enable
  output logic            proc_pll_on_o,    // processor pll power
  output logic            usb_en_o,         // usb rate output enable
  output logic            sel_aud_en_o,     // selectable audio enable
  output logic            fix_aud_en_o,     // fixed audio enable
  output logic            fix_pll_on_o,     // fixed audio pll power
  output logic            aud_sel_24m_o,    // 1 = 24.576, 0 = 22.5792
  output logic      [3:0] spread_depth_o,   // one-hot spread depth
  output logic            spread_on_o       // spread active
);
  // ==========================================================
  // registers and serial engine state
  logic [7:0]          out_en_r;      // output enable control
  logic [7:0]          spread_r;      // spread depth control
  csr_pkg::csr_state_e state_r;       // engine state
  csr_pkg::csr_state_e after_ack_r;   // state after ack slot
  logic [7:0]          shift_r;       // shift register
  logic [3:0]          cnt_r;         // bit counter
  logic [1:0]          ptr_r;         // addressed byte
  logic                byte_mode_r;   // valid byte mode command
  logic                scl_q_r;       // last scl
  logic                sda_q_r;       // last sda
  logic                drive_r;       // sda pulled low
  logic [3:0]          depth_w;       // decoded depth
  logic                spread_w;      // decoded spread active

  // ==========================================================
  // bus condition detection
  wire scl_rise = scl_i & ~scl_q_r;                    // sample edge
  wire scl_fall = ~scl_i & scl_q_r;                    // shift edge
  wire start_c  = scl_i & scl_q_r & sda_q_r & ~sda_i;  // start / repeat
  wire stop_c   = scl_i & scl_q_r & ~sda_q_r & sda_i;  // stop

  // read mux of register bytes
  function automatic logic [7:0] rd_byte(input logic [1:0] p, input logic [7:0] oe,
                                         input logic [7:0] ss);
    case (p)
      csr_pkg::OFF_IDENTITY: rd_byte = {csr_pkg::REVISION_ID, csr_pkg::MAKER_ID};
      csr_pkg::OFF_OUT_EN:   rd_byte = oe;
      csr_pkg::OFF_SPREAD:   rd_byte = ss;
      default:               rd_byte = 8'h00;  // unmapped byte reads zero
    endcase
  endfunction

  // ==========================================================
  // line sampling
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  // ==========================================================
  // serial engine: address, command, data, acks and read byte
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_r     <= csr_pkg::ST_IDLE;
      after_ack_r <= csr_pkg::ST_IDLE;
      shift_r     <= 8'h00;
      cnt_r       <= 4'h0;
      ptr_r       <= 2'h0;
      byte_mode_r <= 1'b0;
      drive_r     <= 1'b0;
    end else if (stop_c) begin
      state_r <= csr_pkg::ST_IDLE;  // stop ends any transaction
      drive_r <= 1'b0;
    end else if (start_c) begin
      state_r <= csr_pkg::ST_ADDR;  // start or repeat start
      cnt_r   <= 4'h0;
      drive_r <= 1'b0;
    end else begin
      case (state_r)
        csr_pkg::ST_ADDR, csr_pkg::ST_CMD, csr_pkg::ST_DATA: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_i};
            cnt_r   <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            if (state_r == csr_pkg::ST_ADDR) begin
              if (shift_r[7:1] != csr_pkg::TARGET_ADDR) begin
                state_r <= csr_pkg::ST_WAIT;
              end else if (shift_r[0]) begin
                // read form, only after a byte mode command
                state_r     <= byte_mode_r ? csr_pkg::ST_ACK : csr_pkg::ST_WAIT;
                drive_r     <= byte_mode_r;
                after_ack_r <= csr_pkg::ST_SEND;
              end else begin
                state_r     <= csr_pkg::ST_ACK;
                drive_r     <= 1'b1;
                after_ack_r <= csr_pkg::ST_CMD;
              end
            end else if (state_r == csr_pkg::ST_CMD) begin
              byte_mode_r <= (shift_r[7:2] == csr_pkg::BYTE_MODE);
              ptr_r       <= shift_r[1:0];
              state_r     <= csr_pkg::ST_ACK;
              drive_r     <= 1'b1;
              after_ack_r <= (shift_r[7:2] == csr_pkg::BYTE_MODE) ?
                             csr_pkg::ST_DATA : csr_pkg::ST_WAIT;
            end else begin
              state_r     <= csr_pkg::ST_ACK;  // ack the data byte
              drive_r     <= 1'b1;
              after_ack_r <= csr_pkg::ST_WAIT; // one byte per write
            end
          end
        end
        csr_pkg::ST_ACK: begin
          if (scl_fall) begin
            state_r <= after_ack_r;
            cnt_r   <= 4'h0;
            if (after_ack_r == csr_pkg::ST_SEND) begin
              shift_r <= rd_byte(ptr_r, out_en_r, spread_r);
              drive_r <= ~rd_byte(ptr_r, out_en_r, spread_r) >> 7 == 8'h01;
            end else begin
              drive_r <= 1'b0;
            end
          end
        end
        csr_pkg::ST_SEND: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              drive_r <= 1'b0;  // release for master nack
              state_r <= csr_pkg::ST_MACK;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              drive_r <= ~shift_r[6];
            end
          end
        end
        csr_pkg::ST_MACK: begin
          if (scl_rise) begin
            state_r <= csr_pkg::ST_WAIT;
          end
        end
        csr_pkg::ST_WAIT, csr_pkg::ST_IDLE: begin
          drive_r <= 1'b0;
        end
        default: begin
          state_r <= csr_pkg::ST_IDLE;
          drive_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // register writes: end of a data byte in byte mode
  wire wr_c = (state_r == csr_pkg::ST_DATA) && scl_fall && (cnt_r == 4'h8) && byte_mode_r;

  // output enable control byte
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      out_en_r <= csr_pkg::RST_OUT_EN;
    end else if (wr_c && ptr_r == csr_pkg::OFF_OUT_EN && !stop_c && !start_c) begin
      out_en_r <= shift_r;
    end
  end

  // spread depth control byte; identity writes fall through
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      spread_r <= csr_pkg::RST_SPREAD;
    end else if (wr_c && ptr_r == csr_pkg::OFF_SPREAD && !stop_c && !start_c) begin
      spread_r <= shift_r;
    end
  end

  // ==========================================================
  // spread decoder
  csr_spread_decode u_dec (
    .code_i   (spread_r[2:0]),
    .depth_o  (depth_w),
    .spread_o (spread_w)
  );

  // ==========================================================
  // registered outputs
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sda_o          <= 1'b0;
      sda_oe_o       <= 1'b0;
      // power-up enable levels follow the control byte one reset value
      ref_en_o       <= csr_pkg::RST_OUT_EN[csr_pkg::BIT_REF_EN];
      proc_clk_en_o  <= csr_pkg::RST_OUT_EN[csr_pkg::BIT_PROC_SS_EN];
      proc_pll_on_o  <= csr_pkg::RST_OUT_EN[csr_pkg::BIT_PROC_SS_EN];
      usb_en_o       <= csr_pkg::RST_OUT_EN[csr_pkg::BIT_USB_EN];
      sel_aud_en_o   <= csr_pkg::RST_OUT_EN[csr_pkg::BIT_SEL_AUD_EN];
      fix_aud_en_o   <= csr_pkg::RST_OUT_EN[csr_pkg::BIT_FIX_AUD_EN];
      fix_pll_on_o   <= csr_pkg::RST_OUT_EN[csr_pkg::BIT_FIX_AUD_EN];
      aud_sel_24m_o  <= csr_pkg::RST_OUT_EN[csr_pkg::BIT_AUD_SEL];
      spread_depth_o <= 4'h2;
      spread_on_o    <= 1'b1;
    end else begin
      sda_o          <= 1'b0;
      sda_oe_o       <= drive_r;
      ref_en_o       <= out_en_r[csr_pkg::BIT_REF_EN];
      proc_clk_en_o  <= out_en_r[csr_pkg::BIT_PROC_SS_EN];
      proc_pll_on_o  <= out_en_r[csr_pkg::BIT_PROC_SS_EN];
      usb_en_o       <= out_en_r[csr_pkg::BIT_USB_EN];
      sel_aud_en_o   <= out_en_r[csr_pkg::BIT_SEL_AUD_EN];
      fix_aud_en_o   <= out_en_r[csr_pkg::BIT_FIX_AUD_EN];
      fix_pll_on_o   <= out_en_r[csr_pkg::BIT_FIX_AUD_EN];
      aud_sel_24m_o  <= out_en_r[csr_pkg::BIT_AUD_SEL];
      spread_depth_o <= depth_w;
      spread_on_o    <= spread_w;
    end
  end
endmodule
`default_nettype wire

// ---- sim/csr_regs_asserts.sv ----
/* port checker for the control register bank.
   assumes scl_i is sampled on sys_clk_i, as the design samples it. */
`timescale 1ns/1ps
`default_nettype none
module csr_regs_asserts (
  input wire logic       sys_clk_i,       // system clock
  input wire logic       reset_i,         // sync reset
  input wire logic       scl_i,           // serial clock level
  input wire logic       sda_oe_o,        // device pulls sda
  input wire logic       ref_en_o,        // reference enable
  input wire logic       proc_clk_en_o,   // processor clock enable
  input wire logic       proc_pll_on_o,   // processor pll power
  input wire logic       usb_en_o,        // usb rate enable
  input wire logic       sel_aud_en_o,    // selectable audio enable
  input wire logic       fix_aud_en_o,    // fixed audio enable
  input wire logic       fix_pll_on_o,    // fixed audio pll power
  input wire logic       aud_sel_24m_o,   // audio rate select
  input wire logic [3:0] spread_depth_o,  // one-hot depth
  input wire logic       spread_on_o      // spread active
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // two samples in a row with scl high
  sequence s_scl_high2;
    scl_i ##1 scl_i;
  endsequence
  property p_powerup;
    $fell(reset_i) |-> ref_en_o && proc_clk_en_o && usb_en_o && sel_aud_en_o
      && !fix_aud_en_o && aud_sel_24m_o && spread_depth_o == 4'h2;
  endproperty
  property p_oe_quiet;
    s_scl_high2 |-> $stable(sda_oe_o);
  endproperty
  property p_oe_edge;
    $changed(sda_oe_o) |-> !scl_i && !$past(scl_i);
  endproperty
  property p_ctl_quiet;
    $changed({ref_en_o, usb_en_o, sel_aud_en_o, aud_sel_24m_o}) |-> !scl_i;
  endproperty
  property p_depth_quiet;
    $changed(spread_depth_o) |-> !scl_i;
  endproperty
  property p_pll_proc;
    proc_pll_on_o == proc_clk_en_o;
  endproperty
  property p_pll_fix;
    fix_pll_on_o == fix_aud_en_o;
  endproperty
  property p_onehot;
    $onehot0(spread_depth_o);
  endproperty
  property p_spread_on;
    spread_on_o == (spread_depth_o != 4'h0);
  endproperty
  a_powerup:     assert property (p_powerup) else $error("bad power-up outputs");
  a_oe_quiet:    assert property (p_oe_quiet) else $error("sda moved, scl high");
  a_oe_edge:     assert property (p_oe_edge) else $error("sda moved too early");
  a_ctl_quiet:   assert property (p_ctl_quiet) else $error("enable moved, scl high");
  a_depth_quiet: assert property (p_depth_quiet) else $error("depth moved, scl high");
  a_pll_proc:    assert property (p_pll_proc) else $error("processor pll mismatch");
  a_pll_fix:     assert property (p_pll_fix) else $error("fixed audio pll mismatch");
  a_onehot:      assert property (p_onehot) else $error("depth not one-hot");
  a_spread_on:   assert property (p_spread_on) else $error("spread flag mismatch");
endmodule
bind csr_regs csr_regs_asserts u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .scl_i(scl_i), .sda_oe_o(sda_oe_o), .ref_en_o(ref_en_o), .proc_clk_en_o(proc_clk_en_o),
  .proc_pll_on_o(proc_pll_on_o), .usb_en_o(usb_en_o), .sel_aud_en_o(sel_aud_en_o),
  .fix_aud_en_o(fix_aud_en_o), .fix_pll_on_o(fix_pll_on_o), .aud_sel_24m_o(aud_sel_24m_o),
  .spread_depth_o(spread_depth_o), .spread_on_o(spread_on_o));
`default_nettype wire

// ---- sim/csr_i2c_host.sv ----
/* two-wire bus master model with start, stop, byte send and receive.
   assumes the bench resolves the wired-and data line into sda_i. */
`timescale 1ns/1ps
`default_nettype none
module csr_i2c_host (
  input  wire logic clk_i,  // system clock
  input  wire logic sda_i,  // resolved data line
  output var logic  scl_o,  // serial clock
  output var logic  sda_o   // master data, 1 = released
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one bit slot, five system clocks per quarter
  task automatic cyc(input logic b, output logic r);
    sda_o <= b;
    wt(5);
    scl_o <= 1'b1;
    wt(5);
    r = sda_i;
    wt(5);
    scl_o <= 1'b0;
    wt(5);
  endtask
  task automatic start();
    sda_o <= 1'b1;
    wt(5);
    scl_o <= 1'b1;
    wt(5);
    sda_o <= 1'b0;
    wt(5);
    scl_o <= 1'b0;
    wt(5);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    wt(5);
    scl_o <= 1'b1;
    wt(5);
    sda_o <= 1'b1;
    wt(5);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) cyc(d[i], r);
    cyc(1'b1, r);
    ack = ~r;
  endtask
  task automatic rx(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) cyc(1'b1, d[i]);
    cyc(1'b1, r);
  endtask
endmodule
`default_nettype wire

// ---- sim/csr_regs_bench.sv ----
/* self-checking bench for the control register bank.
   assumes the host model and the port checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module csr_regs_bench;
  logic sys_clk_i = 1'b0;  // system clock
  logic reset_i   = 1'b1;  // sync reset
  logic scl_w, m_sda, sda_o, sda_oe_o, ref_en_o, proc_clk_en_o, proc_pll_on_o;
  logic usb_en_o, sel_aud_en_o, fix_aud_en_o, fix_pll_on_o, aud_sel_24m_o, spread_on_o;
  logic [3:0] spread_depth_o;  // one-hot depth
  wire sda_w = m_sda & ~(sda_oe_o & ~sda_o);  // wired-and with pull-up
  wire [7:0] outs = {ref_en_o, proc_clk_en_o, proc_pll_on_o, usb_en_o, sel_aud_en_o,
                     fix_aud_en_o, fix_pll_on_o, aud_sel_24m_o};
  int fails = 0;
  int total_checks = 0;
  localparam logic [3:0] DT [8] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h4, 4'h0, 4'h8, 4'h0};
  always #4 sys_clk_i = ~sys_clk_i;
  csr_regs uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .ref_en_o(ref_en_o), .proc_clk_en_o(proc_clk_en_o),
    .proc_pll_on_o(proc_pll_on_o), .usb_en_o(usb_en_o), .sel_aud_en_o(sel_aud_en_o),
    .fix_aud_en_o(fix_aud_en_o), .fix_pll_on_o(fix_pll_on_o), .aud_sel_24m_o(aud_sel_24m_o),
    .spread_depth_o(spread_depth_o), .spread_on_o(spread_on_o));
  csr_i2c_host u_host (.clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_o(m_sda));
  // expected enables from a control byte one value
  function automatic logic [7:0] eo(input logic [7:0] v);
    return {v[7], v[6], v[6], v[5], v[4], v[3], v[3], v[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    output logic [2:0] k);
    u_host.start();
    u_host.tx({a, 1'b0}, k[2]);
    u_host.tx(c, k[1]);
    u_host.tx(d, k[0]);
    u_host.stop();
  endtask
  task automatic rd(input logic [1:0] o, output logic [7:0] d);
    logic [2:0] k;
    u_host.start();
    u_host.tx({csr_pkg::TARGET_ADDR, 1'b0}, k[2]);
    u_host.tx({csr_pkg::BYTE_MODE, o}, k[1]);
    u_host.start();
    u_host.tx({csr_pkg::TARGET_ADDR, 1'b1}, k[0]);
    u_host.rx(d);
    u_host.stop();
    chk("read acks", 8'h07, {5'h0, k});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    fails++;
    wrap_up();
  end
  initial begin
    logic [7:0] d;
    logic [2:0] k;
    logic [7:0] vals [4];
    vals = '{8'h00, 8'h09, 8'hf6, 8'hf7};
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    chk("power-up enables", eo(8'hf7), outs);
    chk("power-up depth", 8'h02, {4'h0, spread_depth_o});
    rd(csr_pkg::OFF_IDENTITY, d);
    chk("identity", {csr_pkg::REVISION_ID, csr_pkg::MAKER_ID}, d);
    rd(csr_pkg::OFF_OUT_EN, d);
    chk("byte one", 8'hf7, d);
    rd(csr_pkg::OFF_SPREAD, d);
    chk("byte two", 8'h02, d);
    $display("test power-up done");
    for (int i = 0; i < 4; i++) begin
      wr(csr_pkg::TARGET_ADDR, {csr_pkg::BYTE_MODE, csr_pkg::OFF_OUT_EN}, vals[i], k);
      chk("write acks", 8'h07, {5'h0, k});
      chk("enables", eo(vals[i]), outs);
      rd(csr_pkg::OFF_OUT_EN, d);
      chk("enable readback", vals[i], d);
    end
    $display("test enables done");
    for (int i = 0; i < 8; i++) begin
      wr(csr_pkg::TARGET_ADDR, {csr_pkg::BYTE_MODE, csr_pkg::OFF_SPREAD}, 8'(i), k);
      chk("depth", {4'h0, DT[i]}, {4'h0, spread_depth_o});
      chk("spread on", {7'h0, DT[i] != 4'h0}, {7'h0, spread_on_o});
      rd(csr_pkg::OFF_SPREAD, d);
      chk("depth readback", 8'(i), d);
    end
    $display("test spread done");
    wr(csr_pkg::TARGET_ADDR, {csr_pkg::BYTE_MODE, csr_pkg::OFF_IDENTITY}, 8'h00, k);
    chk("identity write acks", 8'h07, {5'h0, k});
    rd(csr_pkg::OFF_IDENTITY, d);
    chk("identity kept", {csr_pkg::REVISION_ID, csr_pkg::MAKER_ID}, d);
    rd(2'h3, d);
    chk("unmapped byte", 8'h00, d);
    wr(7'h68, {csr_pkg::BYTE_MODE, csr_pkg::OFF_OUT_EN}, 8'h00, k);
    chk("foreign address ack", 8'h00, {5'h0, k});
    wr(csr_pkg::TARGET_ADDR, 8'h41, 8'h00, k);
    chk("bad command acks", 8'h06, {5'h0, k});
    chk("enables kept", eo(8'hf7), outs);
    $display("test refusals done");
    wrap_up();
  end
endmodule
`default_nettype wire
